// >>> core/dpa_arbiter.sv
// Purpose: decides grant, hold, drop or refusal of port requests
// Assumes: requests and done strobes come from logic on clk_i
// Notes: answers appear one cycle after the request; a held request is granted one cycle after its release
`timescale 1ns/1ns
`include "dpa_defs.svh"

module dpa_arbiter
#(
    parameter int PRIO_CYCLES = `DPA_PRIO_CYCLES,
    parameter int LEN_W = `DPA_LEN_W
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] proto_i,
    input wire logic [1:0] req_i,
    input wire logic [1:0] short_i,
    input wire logic [1:0][LEN_W-1:0] st_len_i,
    input wire logic [1:0] done_i,
    output logic [1:0] grant_o,
    output logic [1:0] nak_o,
    output logic [1:0] drop_o,
    output logic [1:0] st_grant_o,
    output logic [1:0][LEN_W-1:0] st_bytes_o,
    output logic [1:0] busy_o,
    output logic held_o,
    output logic prio_on_o,
    output logic prio_port_o
);

    localparam int CNT_W = $clog2(PRIO_CYCLES + 1);
    localparam logic [CNT_W-1:0] PRIO_LOAD = CNT_W'(PRIO_CYCLES);
    localparam logic [LEN_W-1:0] ST_MAX = LEN_W'(`DPA_ST_MAX_BYTES);

    dpa_slot_if sif ();

    logic [1:0] busy;
    logic [1:0] next_go;
    logic [1:0] next_nak;
    logic [1:0] next_drop;
    logic both_hl;
    logic rel;
    logic prio_on;
    logic prio_port;
    logic prio_armed;
    // refused port waits here so a running window keeps its owner
    logic pend_port;
    logic [CNT_W-1:0] prio_cnt;

    dpa_hold_slot u_slot
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .s(sif)
    );

    // ****************************************************************
    // request decision
    // ****************************************************************
    // the held request goes first when its blocking port finishes, so a
    // new request arriving in the same cycle always sees a busy port
    always_comb
    begin
        logic p;
        logic blocked;
        logic cap;
        logic cap_port;
        p = 1'b0;
        blocked = 1'b0;
        cap = 1'b0;
        cap_port = 1'b0;
        both_hl = (proto_i == {2{dpa_pkg::host_link_protocol}});
        rel = sif.occupied && busy[!sif.port] && done_i[!sif.port];
        next_go = 2'h0;
        next_nak = 2'h0;
        next_drop = 2'h0;
        if (rel)
        begin
            next_go[sif.port] = 1'b1;
        end
        for (int i = 0; i < 2; i++)
        begin
            p = (i == 0) ? (prio_on && prio_port) : !(prio_on && prio_port);
            if (req_i[p] && !short_i[p])
            begin
                blocked = busy[!p] || next_go[!p] || (prio_on && prio_port != p);
                if (busy[p] || (sif.occupied && sif.port == p))
                begin
                    next_drop[p] = 1'b1;
                end
                else if (!blocked)
                begin
                    next_go[p] = 1'b1;
                end
                else if (both_hl)
                begin
                    next_nak[p] = 1'b1;
                end
                else if (!sif.occupied && !cap)
                begin
                    cap = 1'b1;
                    cap_port = p;
                end
                else
                begin
                    next_drop[p] = 1'b1;
                end
            end
        end
        sif.capture = cap;
        sif.cap_port = cap_port;
        sif.release_req = rel;
    end

    // ****************************************************************
    // port busy state and answers
    // ****************************************************************
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            busy <= 2'h0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (next_go[i])
                begin
                    busy[i] <= 1'b1;
                end
                else if (done_i[i])
                begin
                    busy[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            grant_o <= 2'h0;
            nak_o <= 2'h0;
            drop_o <= 2'h0;
        end
        else
        begin
            grant_o <= next_go;
            nak_o <= next_nak;
            drop_o <= next_drop;
        end
    end

    // ****************************************************************
    // short transfers, never deferred and never marking a port busy
    // ****************************************************************
    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_short
            always_ff @(posedge clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    st_grant_o[g] <= 1'b0;
                    st_bytes_o[g] <= '0;
                end
                else
                begin
                    st_grant_o[g] <= req_i[g] && short_i[g];
                    if (st_len_i[g] > ST_MAX)
                    begin
                        st_bytes_o[g] <= ST_MAX;
                    end
                    else
                    begin
                        st_bytes_o[g] <= st_len_i[g];
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // priority window after a refusal
    // ****************************************************************
    // window starts only once both ports are idle and nothing is starting;
    // a refusal inside a running window waits for the next one
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prio_armed <= 1'b0;
            pend_port <= 1'b0;
            prio_port <= 1'b0;
            prio_on <= 1'b0;
            prio_cnt <= '0;
        end
        else
        begin
            if (next_nak != 2'h0)
            begin
                prio_armed <= 1'b1;
                pend_port <= next_nak[1];
            end
            else if (prio_armed && !prio_on && busy == 2'h0
                     && next_go == 2'h0)
            begin
                prio_armed <= 1'b0;
                prio_port <= pend_port;
                prio_on <= 1'b1;
                prio_cnt <= PRIO_LOAD;
            end
            if (prio_on)
            begin
                prio_cnt <= prio_cnt - 1'b1;
                if (prio_cnt == CNT_W'(1))
                begin
                    prio_on <= 1'b0;
                end
            end
        end
    end

    assign busy_o = busy;
    assign held_o = sif.occupied;
    assign prio_on_o = prio_on;
    assign prio_port_o = prio_port;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_release;
        sif.occupied && busy[!sif.port] && done_i[!sif.port];
    endsequence

    chk_mixed_no_nak: assert property (
        (proto_i[0] != proto_i[1]) |=> (nak_o == 2'h0))
        else $error("refusal issued with mixed protocols");

    chk_slot_drop: assert property (
        (sif.occupied && !rel && req_i[0] && !short_i[0] && busy[1]
         && !both_hl) |=> drop_o[0])
        else $error("request beyond the held one not dropped");

    chk_short_any: assert property (
        (req_i[1] && short_i[1] && busy[0]) |=> (st_grant_o[1] && !nak_o[1]))
        else $error("short transfer deferred or refused");

    chk_short_len: assert property (
        st_grant_o[0] |-> (st_bytes_o[0] <= ST_MAX && st_bytes_o[0] != '0
        || $past(st_len_i[0]) == '0))
        else $error("short transfer longer than four bytes");

    chk_release_go: assert property (
        s_release |=> (grant_o[$past(sif.port)] && !sif.occupied
        && busy[$past(sif.port)]))
        else $error("held request not started on release");

    chk_nak_busy: assert property (
        (both_hl && busy[1] && !busy[0] && req_i[0] && !short_i[0])
        |=> (nak_o[0] && !grant_o[0]))
        else $error("conflicting host-link request not refused");

    chk_prio_load: assert property (
        $rose(prio_on) |-> (prio_cnt == PRIO_LOAD
        && prio_port == $past(pend_port)))
        else $error("priority window wrong length");

    chk_prio_block: assert property (
        (prio_on && req_i[!prio_port] && !short_i[!prio_port])
        |=> !grant_o[!prio_port])
        else $error("non-priority port granted inside window");

endmodule : dpa_arbiter

// >>> core/dpa_hold_slot.sv
// Purpose: single-entry holding slot for one deferred request
// Assumes: capture only while free, release only while held
// Notes: a capture while held is ignored, never stacked
`timescale 1ns/1ns
module dpa_hold_slot
(
    input wire logic clk_i,
    input wire logic rst_i,
    dpa_slot_if.slot s
);

    dpa_pkg::dpa_slot_st_t state;
    logic held_port;

    // ****************************************************************
    // slot state
    // ****************************************************************
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= dpa_pkg::slot_free;
        end
        else
        begin
            case (state)
                dpa_pkg::slot_free:
                begin
                    if (s.capture)
                    begin
                        state <= dpa_pkg::slot_held;
                    end
                end
                dpa_pkg::slot_held:
                begin
                    if (s.release_req)
                    begin
                        state <= dpa_pkg::slot_free;
                    end
                end
                default:
                begin
                    state <= dpa_pkg::slot_free;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            held_port <= 1'b0;
        end
        else if (s.capture && state == dpa_pkg::slot_free)
        begin
            held_port <= s.cap_port;
        end
    end

    assign s.occupied = (state == dpa_pkg::slot_held);
    assign s.port = held_port;

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_slot_capture: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!s.occupied && s.capture) |=> (s.occupied && s.port == $past(s.cap_port)))
        else $error("slot not marked occupied after capture");

    chk_slot_nostack: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s.occupied && !s.release_req) |=> (s.occupied && $stable(s.port)))
        else $error("held request overwritten or lost");

endmodule : dpa_hold_slot

// >>> inc/dpa_defs.svh
// Purpose: timing and size constants for the dual port request arbiter
// Assumes: 20 MHz system clock
// Notes: counts derived from times, rounded to whole cycles
`ifndef DPA_DEFS_SVH
`define DPA_DEFS_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define DPA_CLK_HZ 20000000
`define DPA_PRIO_MS 200
`define DPA_PRIO_CYCLES (`DPA_PRIO_MS * (`DPA_CLK_HZ / 1000))

// ****************************************************************
// short-transfer sizing
// ****************************************************************
`define DPA_ST_MAX_BYTES 4
`define DPA_LEN_W 3

`endif

// >>> inc/dpa_pkg.sv
// Purpose: shared types for the dual port request arbiter
// Assumes: two serial ports, index 0 and 1
// Notes: protocol code matches the per-port configuration inputs
package dpa_pkg;

    typedef enum logic
    {
        host_link_protocol,
        remote_terminal_protocol
    } dpa_proto_t;

    typedef enum logic
    {
        slot_free,
        slot_held
    } dpa_slot_st_t;

endpackage : dpa_pkg

// >>> inc/dpa_slot_if.sv
// Purpose: link between arbiter and its single-entry holding slot
// Assumes: one clock domain
// Notes: capture and release are one-cycle strobes
`timescale 1ns/1ns
interface dpa_slot_if;
    logic capture;
    logic cap_port;
    logic release_req;
    logic occupied;
    logic port;

    modport arb
    (
        output capture,
        output cap_port,
        output release_req,
        input occupied,
        input port
    );

    modport slot
    (
        input capture,
        input cap_port,
        input release_req,
        output occupied,
        output port
    );
endinterface : dpa_slot_if

// >>> sim/dpa_far_dev.sv
// Purpose: far side of both ports, runs each granted session to its end
// Assumes: one session per grant, length set by the bench
// Notes: sessions end for any nonzero sess_i, so a deferred request is never starved
`timescale 1ns/1ns
module dpa_far_dev
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] grant_i,
    input wire logic [7:0] sess_i,
    output logic [1:0] done_o
);
    logic [1:0][7:0] remain;

    // bounded session keeps the far timeout covering any deferral
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            remain <= '0;
            done_o <= 2'h0;
        end
        else
        begin
            for (int p = 0; p < 2; p++)
            begin
                done_o[p] <= 1'b0;
                if (grant_i[p])
                    remain[p] <= sess_i;
                else if (remain[p] == 8'h01)
                begin
                    remain[p] <= 8'h00;
                    done_o[p] <= 1'b1;
                end
                else if (remain[p] != 8'h00)
                    remain[p] <= remain[p] - 8'h01;
            end
        end
    end
endmodule : dpa_far_dev

// >>> sim/testbench.sv
// Purpose: self-checking bench for the dual port request arbiter
// Assumes: priority window shortened to 16 cycles
// Notes: every scenario starts from a fresh reset
`timescale 1ns/1ns
`define CHK(act, exp) \
    begin \
        total_checks++; \
        if ((act) !== (exp)) \
        begin \
            mismatches++; \
            $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp); \
        end \
    end
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [1:0] proto = 2'h0;
    logic [1:0] req = 2'h0;
    logic [1:0] short_r = 2'h0;
    logic [1:0][2:0] st_len = '0;
    logic [1:0] done, grant_o, nak_o, drop_o, st_grant_o, busy_o;
    logic [1:0][2:0] st_bytes_o;
    logic held_o, prio_on_o, prio_port_o;
    int mismatches = 0;
    int total_checks = 0;

    always #25 clk_i = ~clk_i;

    dpa_arbiter #(.PRIO_CYCLES(16)) u_dut
    (
        .clk_i(clk_i), .rst_i(rst_i), .proto_i(proto), .req_i(req),
        .short_i(short_r), .st_len_i(st_len), .done_i(done),
        .grant_o(grant_o), .nak_o(nak_o), .drop_o(drop_o),
        .st_grant_o(st_grant_o), .st_bytes_o(st_bytes_o),
        .busy_o(busy_o), .held_o(held_o), .prio_on_o(prio_on_o),
        .prio_port_o(prio_port_o)
    );

    dpa_far_dev u_far
    (
        .clk_i(clk_i), .rst_i(rst_i), .grant_i(grant_o),
        .sess_i(8'h1E), .done_o(done)
    );

    // ****************************************************************
    // drivers
    // ****************************************************************
    task automatic reset_dut(input logic [1:0] p);
        @(posedge clk_i);
        #2;
        rst_i = 1'b1;
        proto = p;
        repeat (12) @(posedge clk_i);
        #2;
        rst_i = 1'b0;
    endtask : reset_dut

    // answer is settled 2 ns after the taking edge
    task automatic send(input int p, input logic s, input logic [2:0] n);
        @(posedge clk_i);
        #2;
        req[p] = 1'b1;
        short_r[p] = s;
        st_len[p] = n;
        @(posedge clk_i);
        #2;
        req = 2'h0;
        short_r = 2'h0;
    endtask : send

    task automatic wait_grant0;
        for (int i = 0; i < 100 && grant_o[0] !== 1'b1; i++)
        begin
            @(posedge clk_i);
            #2;
        end
    endtask : wait_grant0

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_hold(input logic [1:0] p);
        reset_dut(p);
        send(1, 1'b0, 3'h0);
        `CHK(grant_o, 2'h2)
        send(0, 1'b0, 3'h0);
        `CHK(grant_o | nak_o | drop_o, 2'h0)
        `CHK(held_o, 1'b1)
        send(0, 1'b0, 3'h0);
        `CHK(drop_o, 2'h1)
        `CHK(held_o, 1'b1)
        wait_grant0();
        `CHK(grant_o, 2'h1)
        `CHK(busy_o, 2'h1)
        `CHK(held_o, 1'b0)
    endtask : t_hold

    task automatic t_short(input logic [1:0] p);
        reset_dut(p);
        send(0, 1'b1, 3'h6);
        `CHK(st_grant_o, 2'h1)
        `CHK(st_bytes_o[0], 3'h4)
        send(0, 1'b0, 3'h0);
        for (int n = 1; n < 8; n++)
        begin
            send(1, 1'b1, 3'(n));
            `CHK(st_grant_o, 2'h2)
            `CHK(st_bytes_o[1], (n > 4) ? 3'h4 : 3'(n))
            `CHK(busy_o, 2'h1)
            `CHK(nak_o | drop_o, 2'h0)
        end
    endtask : t_short

    task automatic t_nak;
        reset_dut(2'h0);
        send(1, 1'b0, 3'h0);
        send(0, 1'b0, 3'h0);
        `CHK(nak_o, 2'h1)
        `CHK(held_o, 1'b0)
        for (int i = 0; i < 100 && prio_on_o !== 1'b1; i++)
        begin
            @(posedge clk_i);
            #2;
        end
        `CHK(prio_on_o, 1'b1)
        `CHK(prio_port_o, 1'b0)
        send(1, 1'b0, 3'h0);
        `CHK(nak_o, 2'h2)
        send(0, 1'b0, 3'h0);
        `CHK(grant_o, 2'h1)
    endtask : t_nak

    // ****************************************************************
    // verdict
    // ****************************************************************
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // whole run needs well under 2000 cycles
    initial
    begin
        #(50 * 20000);
        mismatches++;
        results();
    end

    initial
    begin
        t_hold(2'h2);
        t_hold(2'h1);
        t_hold(2'h3);
        t_short(2'h1);
        t_short(2'h0);
        t_nak();
        results();
    end
endmodule : testbench
